// ==== hdl/bcsc_top.sv ====
/*
 Bank 1 chip select control register with its access sequencer.
 Assumes an AXI4-Lite master, one access request at a time, and a
 multiplexed memory whose wait pin is asynchronous to clk_in.
*/
`timescale 1ns/1ps
`include "bcsc_params.svh"
module bcsc_top
	import bcsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Access requests
	input wire logic acc_req_in,
	input wire logic acc_write_in,
	input wire logic acc_burst_in,
	input wire logic acc_wrap_in,
	input wire logic [7:0] acc_len_in,
	input wire logic [23:0] acc_addr_in,
	output logic acc_ready_out,
	output logic acc_done_out,
	output logic acc_refused_out,
	// Memory side
	input wire logic memory_wait_in,
	output logic mem_select_out,
	output logic mem_latch_out,
	output logic mem_write_out,
	output logic mem_sync_out,
	output logic mem_clk_out,
	output logic mem_beat_out,
	output logic mem_wide_out,
	output logic mem_timing_out,
	output logic [23:0] mem_addr_out
);
	logic [31:0] bank1_chip_select_control_reg;
	logic aw_have_reg, w_have_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	bcsc_state_type state_reg;
	logic wrap_reg;
	logic [7:0] len_reg, remaining_reg;
	logic [23:0] next_addr;
	logic split, stall, refuse, req_sync;
	logic [2:0] burst_page_size;
	logic [1:0] external_bus_width, memory_kind;
	logic write_sync_select, async_wait_enable, split_rw_timing, sync_wait_enable;
	logic write_allow, wait_timing_select, wrapped_burst_allow, wait_polarity;
	logic sync_burst_allow, nor_access_allow, bank_enable;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	assign write_sync_select = bank1_chip_select_control_reg[`BCSC_WSYNC_BIT];
	assign burst_page_size = bank1_chip_select_control_reg[`BCSC_PAGE_LSB +: 3];
	assign async_wait_enable = bank1_chip_select_control_reg[`BCSC_AWAIT_BIT];
	assign split_rw_timing = bank1_chip_select_control_reg[`BCSC_SPLIT_BIT];
	assign sync_wait_enable = bank1_chip_select_control_reg[`BCSC_SWAIT_BIT];
	assign write_allow = bank1_chip_select_control_reg[`BCSC_WALLOW_BIT];
	assign wait_timing_select = bank1_chip_select_control_reg[`BCSC_WTIME_BIT];
	assign wrapped_burst_allow = bank1_chip_select_control_reg[`BCSC_WRAP_BIT];
	assign wait_polarity = bank1_chip_select_control_reg[`BCSC_WPOL_BIT];
	assign sync_burst_allow = bank1_chip_select_control_reg[`BCSC_SBURST_BIT];
	assign nor_access_allow = bank1_chip_select_control_reg[`BCSC_NOR_BIT];
	assign external_bus_width = bank1_chip_select_control_reg[`BCSC_WIDTH_LSB +: 2];
	assign memory_kind = bank1_chip_select_control_reg[`BCSC_KIND_LSB +: 2];
	assign bank_enable = bank1_chip_select_control_reg[`BCSC_ENABLE_BIT];

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `BCSC_RESP_OKAY;
			bank1_chip_select_control_reg <= `BCSC_CTRL_RESET;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !s_axi_bvalid_out)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				// [RQ1] partial words refused
				if (aw_addr_reg == `BCSC_CTRL_ADDR && w_strb_reg == 4'hf)
				begin
					// [RQ17] reserved bits held
					bank1_chip_select_control_reg <= (w_data_reg & `BCSC_CTRL_WMASK) | `BCSC_CTRL_FIXED;
					s_axi_bresp_out <= `BCSC_RESP_OKAY;
				end
				else
					s_axi_bresp_out <= `BCSC_RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in)
			begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `BCSC_RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= `BCSC_RESP_OKAY;
			if (s_axi_araddr_in == `BCSC_CTRL_ADDR)
				s_axi_rdata_out <= bank1_chip_select_control_reg;
			else if (s_axi_araddr_in == `BCSC_STAT_ADDR)
				s_axi_rdata_out <= {30'h00000000, mem_sync_out & ~acc_ready_out, ~acc_ready_out};
			else
			begin
				s_axi_rdata_out <= 32'h00000000;
				s_axi_rresp_out <= `BCSC_RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// [RQ12] [RQ13] [RQ14] unusable setups refused
	assign refuse = !bank_enable || memory_kind == `BCSC_KIND_RSVD || external_bus_width[1]
		|| (memory_kind == `BCSC_KIND_NOR && !nor_access_allow) || (acc_write_in && !write_allow);
	// [RQ2] [RQ3] [RQ11] clocking mode chosen
	assign req_sync = acc_write_in ? write_sync_select : (acc_burst_in && sync_burst_allow);

	bcsc_burst_step bcsc_burst_step_inst (
		.addr_in(mem_addr_out),
		.len_in(len_reg),
		.wide_in(mem_wide_out),
		.wrap_in(wrap_reg),
		.sync_in(mem_sync_out),
		.page_in(burst_page_size),
		.wrap_allow_in(wrapped_burst_allow),
		.next_addr_out(next_addr),
		.split_out(split)
	);

	bcsc_wait_sense bcsc_wait_sense_inst (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.memory_wait_in(memory_wait_in),
		.sync_in(mem_sync_out),
		.async_en_in(async_wait_enable),
		.sync_en_in(sync_wait_enable),
		.polarity_in(wait_polarity),
		.timing_in(wait_timing_select),
		.stall_out(stall)
	);

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			state_reg <= ST_IDLE;
			acc_ready_out <= 1'b1;
			acc_done_out <= 1'b0;
			acc_refused_out <= 1'b0;
			mem_select_out <= 1'b0;
			mem_latch_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_sync_out <= 1'b0;
			mem_beat_out <= 1'b0;
			mem_wide_out <= 1'b1;
			mem_timing_out <= 1'b0;
			mem_addr_out <= 24'h000000;
			wrap_reg <= 1'b0;
			len_reg <= 8'h01;
			remaining_reg <= 8'h01;
		end
		else
		begin
			acc_done_out <= 1'b0;
			acc_refused_out <= 1'b0;
			mem_beat_out <= 1'b0;
			mem_latch_out <= 1'b0;
			case (state_reg)
				ST_IDLE:
					if (acc_req_in && refuse)
						acc_refused_out <= 1'b1;
					else if (acc_req_in)
					begin
						state_reg <= ST_ADDR;
						acc_ready_out <= 1'b0;
						mem_select_out <= 1'b1;
						mem_latch_out <= 1'b1;
						mem_write_out <= acc_write_in;
						mem_sync_out <= req_sync;
						mem_wide_out <= external_bus_width == `BCSC_WIDTH_16;
						// [RQ6] write timing set chosen
						mem_timing_out <= acc_write_in && split_rw_timing;
						mem_addr_out <= acc_addr_in;
						wrap_reg <= acc_wrap_in;
						len_reg <= (acc_len_in == 8'h00) ? 8'h01 : acc_len_in;
						remaining_reg <= (acc_len_in == 8'h00) ? 8'h01 : acc_len_in;
					end
				ST_ADDR:
					state_reg <= ST_DATA;
				ST_DATA:
					if (!stall)
					begin
						mem_beat_out <= 1'b1;
						mem_addr_out <= next_addr;
						remaining_reg <= remaining_reg - 8'h01;
						if (remaining_reg == 8'h01)
						begin
							state_reg <= ST_IDLE;
							mem_select_out <= 1'b0;
							acc_done_out <= 1'b1;
							acc_ready_out <= 1'b1;
						end
						// [RQ4] [RQ9] burst split and restart
						else if (split)
						begin
							state_reg <= ST_GAP;
							mem_select_out <= 1'b0;
						end
					end
				ST_GAP:
				begin
					state_reg <= ST_ADDR;
					mem_select_out <= 1'b1;
					mem_latch_out <= 1'b1;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
			// Disabling the bank mid-burst abandons it rather than finishing a stale transfer.
			// [RQ16] disabled bank stops accesses
			if (!bank_enable && state_reg != ST_IDLE)
			begin
				state_reg <= ST_IDLE;
				mem_select_out <= 1'b0;
				mem_latch_out <= 1'b0;
				acc_ready_out <= 1'b1;
				acc_refused_out <= 1'b1;
			end
		end
	end

	// The memory clock runs only while a synchronous access holds the bank.
	// [RQ3] memory clock for synchronous mode
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			mem_clk_out <= 1'b0;
		else if (mem_sync_out && mem_select_out)
			mem_clk_out <= ~mem_clk_out;
		else
			mem_clk_out <= 1'b0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	logic start;
	logic [23:0] pmask;
	assign start = state_reg == ST_IDLE && acc_req_in && !refuse;
	assign pmask = {13'h0000, bcsc_page_bytes(burst_page_size)} - 24'h000001;

	sequence seq_restart;
		!mem_select_out ##1 mem_select_out && mem_latch_out;
	endsequence

	AST_ASYNC_WRITE: assert property (start && acc_write_in && !write_sync_select |=> !mem_sync_out) // [RQ2]
		else $error("write not asynchronous");
	AST_SYNC_WRITE: assert property (start && acc_write_in && write_sync_select // [RQ3]
		|=> mem_sync_out ##1 mem_clk_out)
		else $error("write not synchronous");
	AST_PAGE_SPLIT: assert property (state_reg == ST_DATA && mem_sync_out && burst_page_size != 3'h0 // [RQ4]
		&& pmask[10:0] != 11'h7ff && (next_addr & pmask) == 24'h000000 |-> split)
		else $error("page boundary not split");
	AST_TIMING_SET: assert property (start // [RQ6]
		|=> mem_timing_out == ($past(acc_write_in) && $past(split_rw_timing)))
		else $error("timing set wrong");
	AST_SPLIT_RESTART: assert property (state_reg == ST_DATA && !stall && bank_enable // [RQ9]
		&& remaining_reg != 8'h01 && split ##1 bank_enable |-> seq_restart)
		else $error("split access not restarted");
	AST_NO_SYNC_READ: assert property (start && !acc_write_in && !sync_burst_allow |=> !mem_sync_out) // [RQ11]
		else $error("synchronous read while forbidden");
	AST_NOR_REFUSE: assert property (state_reg == ST_IDLE && acc_req_in && memory_kind == `BCSC_KIND_NOR // [RQ12]
		&& !nor_access_allow |=> acc_refused_out && acc_ready_out && !mem_select_out)
		else $error("NOR access not refused");
	AST_WIDTH: assert property (start |=> mem_wide_out == ($past(external_bus_width) == `BCSC_WIDTH_16)) // [RQ13]
		else $error("bus width wrong");
	AST_KIND_RSVD: assert property (state_reg == ST_IDLE && acc_req_in && memory_kind == `BCSC_KIND_RSVD // [RQ14]
		|=> acc_refused_out)
		else $error("reserved memory kind accepted");
	AST_BANK_OFF: assert property (!bank_enable |=> !mem_select_out) // [RQ16]
		else $error("access while bank disabled");
endmodule : bcsc_top

// ==== hdl/bcsc_params.svh ====
/*
 Constants for the bank 1 chip select control block: offsets, fields, resets.
 Assumes an AXI4-Lite master with 32-bit data and one 20 MHz clock.
*/
// Behaviour
// [RQ1] Software uses full 32-bit word accesses only.
// [RQ2] Write mode 0 gives asynchronous writes.
// [RQ3] Write mode 1 gives synchronous clocked writes.
// [RQ4] Synchronous bursts split at configured page boundary.
// [RQ5] Bit 15 enables wait input when asynchronous.
// [RQ6] Bit 14 selects separate write timing set.
// [RQ7] Bit 13 enables wait input when synchronous.
// [RQ8] Bit 11 selects early or current wait.
// [RQ9] Bit 10 clear splits wrapped bursts in two.
// [RQ10] Bit 9 sets synchronous wait polarity.
// [RQ11] Bit 8 clear forbids synchronous burst reads.
// [RQ12] Bit 6 clear forbids NOR flash access.
// [RQ13] Bits 5:4 select 8 or 16 bit bus.
// [RQ14] Bits 3:2 select memory kind, NOR default.
// [RQ15] Software keeps shared address/data bit set.
// [RQ16] Bit 0 clear blocks all external accesses.
// [RQ17] Software keeps reserved bits at reset values.
`ifndef BCSC_PARAMS_SVH
`define BCSC_PARAMS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BCSC_CTRL_ADDR 12'h000
`define BCSC_STAT_ADDR 12'h040
`define BCSC_CTRL_RESET 32'h000030db
`define BCSC_CTRL_WMASK 32'h000fff7f
`define BCSC_CTRL_FIXED 32'h00000080
`define BCSC_RESP_OKAY 2'h0
`define BCSC_RESP_SLVERR 2'h2
// ----------------------------------------
// Control fields
// ----------------------------------------
`define BCSC_WSYNC_BIT 19
`define BCSC_PAGE_LSB 16
`define BCSC_AWAIT_BIT 15
`define BCSC_SPLIT_BIT 14
`define BCSC_SWAIT_BIT 13
`define BCSC_WALLOW_BIT 12
`define BCSC_WTIME_BIT 11
`define BCSC_WRAP_BIT 10
`define BCSC_WPOL_BIT 9
`define BCSC_SBURST_BIT 8
`define BCSC_NOR_BIT 6
`define BCSC_WIDTH_LSB 4
`define BCSC_KIND_LSB 2
`define BCSC_SHARED_BIT 1
`define BCSC_ENABLE_BIT 0
`define BCSC_KIND_NOR 2'h2
`define BCSC_KIND_RSVD 2'h3
`define BCSC_WIDTH_16 2'h1
`endif

// ==== hdl/bcsc_pkg.sv ====
/*
 Types and shared decode for the bank 1 chip select control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bcsc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_GAP} bcsc_state_type;

	// Reserved page codes behave as no split.
	function automatic logic [10:0] bcsc_page_bytes(input logic [2:0] code);
		case (code)
			3'h1: bcsc_page_bytes = 11'h080;
			3'h2: bcsc_page_bytes = 11'h100;
			3'h3: bcsc_page_bytes = 11'h200;
			3'h4: bcsc_page_bytes = 11'h400;
			default: bcsc_page_bytes = 11'h000;
		endcase
	endfunction : bcsc_page_bytes
endpackage : bcsc_pkg

// ==== hdl/bcsc_wait_sense.sv ====
/*
 Synchronises the memory wait pin and decides when the current beat stalls.
 Assumes the wait pin is asynchronous to clk_in.
*/
`timescale 1ns/1ps
module bcsc_wait_sense
	import bcsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Pin and settings
	input wire logic memory_wait_in,
	input wire logic sync_in,
	input wire logic async_en_in,
	input wire logic sync_en_in,
	input wire logic polarity_in,
	input wire logic timing_in,
	// Result
	output logic stall_out
);
	logic s1_reg, s2_reg, s3_reg, level_reg, late_reg;
	logic active;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level_reg <= 1'b1;
		end
		else
		begin
			s1_reg <= memory_wait_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end
	end

	// [RQ10] polarity applied
	assign active = sync_in ? (polarity_in ? level_reg : ~level_reg) : ~level_reg;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			late_reg <= 1'b0;
		else
			late_reg <= active;
	end

	// [RQ5] [RQ7] [RQ8] wait enables and timing
	always_comb
	begin
		if (sync_in)
			stall_out = sync_en_in & (timing_in ? active : late_reg);
		else
			stall_out = async_en_in & active;
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_ASYNC_WAIT_OFF: assert property (!sync_in && !async_en_in |-> !stall_out) // [RQ5]
		else $error("asynchronous wait used while disabled");
	AST_ASYNC_WAIT_ON: assert property (!sync_in && async_en_in && !level_reg |-> stall_out) // [RQ5]
		else $error("asynchronous wait ignored");
	AST_SYNC_WAIT_OFF: assert property (sync_in && !sync_en_in |-> !stall_out) // [RQ7]
		else $error("synchronous wait used while disabled");
	AST_WAIT_EARLY: assert property (active && sync_in && sync_en_in && !timing_in ##1 // [RQ8]
		sync_in && sync_en_in && !timing_in |-> stall_out)
		else $error("early wait not applied one cycle later");
	AST_WAIT_POL: assert property (sync_in && sync_en_in && timing_in && level_reg == polarity_in // [RQ10]
		|-> stall_out)
		else $error("wait polarity wrong");
endmodule : bcsc_wait_sense

// ==== hdl/bcsc_burst_step.sv ====
/*
 Next beat address and split decision for one burst beat.
 Assumes wrapped lengths are powers of two.
*/
`timescale 1ns/1ps
module bcsc_burst_step
	import bcsc_pkg::*;
(
	// Beat state
	input wire logic [23:0] addr_in,
	input wire logic [7:0] len_in,
	input wire logic wide_in,
	input wire logic wrap_in,
	input wire logic sync_in,
	// Settings
	input wire logic [2:0] page_in,
	input wire logic wrap_allow_in,
	// Result
	output logic [23:0] next_addr_out,
	output logic split_out
);
	logic [23:0] step, inc, bytes, mask, page, pmask;
	logic wrap_cross, page_cross;

	assign step = wide_in ? 24'h000002 : 24'h000001;
	assign inc = addr_in + step;
	assign bytes = wide_in ? {15'h0000, len_in, 1'b0} : {16'h0000, len_in};
	assign mask = bytes - 24'h000001;
	assign next_addr_out = wrap_in ? ((addr_in & ~mask) | (inc & mask)) : inc;
	assign wrap_cross = wrap_in && ((inc & mask) == 24'h000000);
	assign page = {13'h0000, bcsc_page_bytes(page_in)};
	assign pmask = page - 24'h000001;
	// [RQ4] page boundary reached
	assign page_cross = (page != 24'h000000) && ((next_addr_out & pmask) == 24'h000000);
	// [RQ9] wrapped burst split
	assign split_out = !sync_in || page_cross || (wrap_cross && !wrap_allow_in);
endmodule : bcsc_burst_step

// ==== tb/bcsc_mem_model.sv ====
/*
 Model of the multiplexed memory behind bank 1; it drives the wait pin.
 Assumes the bench says when to stall and at which active level.
*/
`timescale 1ns/1ps
module bcsc_mem_model
(
	// Clock
	input wire logic clk_in,
	// Controller side
	input wire logic mem_select_in,
	// Bench control
	input wire logic stall_in,
	input wire logic active_high_in,
	// Wait pin
	output logic memory_wait_out
);
	// ----------------------------------------
	// Wait pin
	// ----------------------------------------
	initial memory_wait_out = 1'h1;
	// Wait before stall
	// The pin idles at its inactive level, so an unselected part never stalls the bus.
	always @(posedge clk_in)
	begin
		memory_wait_out <= (mem_select_in && stall_in) ? active_high_in : ~active_high_in;
	end
endmodule : bcsc_mem_model

// ==== tb/ext_mem_bank1_chip_select_control_tb.sv ====
/*
 Self-checking bench for the bank 1 chip select control block.
 Assumes the design files and the memory model are compiled first.
*/
`timescale 1ns/1ps
`include "bcsc_params.svh"
module ext_mem_bank1_chip_select_control_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [31:0] DEF = `BCSC_CTRL_RESET;
	localparam logic [31:0] SB = DEF | 32'h00000100;
	logic clk_in = 1'h0, sys_rst_in = 1'h1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic acc_req = 1'h0, acc_write = 1'h0, acc_burst = 1'h0, acc_wrap = 1'h0;
	logic [7:0] acc_len = 8'h1;
	logic [23:0] acc_addr = 24'h0;
	logic stall = 1'h0, act_high = 1'h0;
	logic mem_wait, awready, wready, bvalid, arready, rvalid, acc_ready, acc_done, acc_refused;
	logic mem_select, mem_latch, mem_sync, mem_wide, mem_timing, mem_write, mem_clk, mem_beat;
	logic [23:0] mem_addr, ad;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic rf, sy, tm, wd, wr, ck;
	int lat, cyc, nb, n_mismatch = 0, total_checks = 0, cycles = 0;

	always #25 clk_in = ~clk_in;

	bcsc_top bcsc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.acc_req_in(acc_req), .acc_write_in(acc_write), .acc_burst_in(acc_burst), .acc_wrap_in(acc_wrap),
		.acc_len_in(acc_len), .acc_addr_in(acc_addr), .acc_ready_out(acc_ready), .acc_done_out(acc_done),
		.acc_refused_out(acc_refused), .memory_wait_in(mem_wait), .mem_select_out(mem_select),
		.mem_latch_out(mem_latch), .mem_write_out(mem_write), .mem_sync_out(mem_sync), .mem_clk_out(mem_clk),
		.mem_beat_out(mem_beat), .mem_wide_out(mem_wide), .mem_timing_out(mem_timing), .mem_addr_out(mem_addr));

	bcsc_mem_model bcsc_mem_model_inst (.clk_in(clk_in), .mem_select_in(mem_select), .stall_in(stall),
		.active_high_in(act_high), .memory_wait_out(mem_wait));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk_in);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clk_in);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axr

	// Every value keeps the shared bus bit and the reserved bits as they reset.
	task automatic set_ctrl(input logic [31:0] v);
		logic [1:0] r;
		axw(12'h000, v, 4'hf, r);
	endtask : set_ctrl

	// Stall asks the memory to hold wait active for that many cycles after the request.
	task automatic acc(input logic w, input logic b, input logic p, input logic [7:0] n, input logic [23:0] a,
		input int st);
		lat = 0;
		cyc = 0;
		nb = 0;
		ck = 1'h0;
		rf = 1'h0;
		@(posedge clk_in);
		acc_req <= 1'h1;
		acc_write <= w;
		acc_burst <= b;
		acc_wrap <= p;
		acc_len <= n;
		acc_addr <= a;
		stall <= (st > 0);
		@(posedge clk_in);
		acc_req <= 1'h0;
		while (cyc < 300)
		begin
			@(posedge clk_in);
			cyc++;
			if (cyc == st) stall <= 1'h0;
			if (mem_latch === 1'h1)
			begin
				lat++;
				sy = mem_sync;
				tm = mem_timing;
				wd = mem_wide;
				wr = mem_write;
				ad = mem_addr;
			end
			if (mem_beat === 1'h1) nb++;
			if (mem_clk === 1'h1) ck = 1'h1;
			if (acc_done === 1'h1 || acc_refused === 1'h1) break;
		end
		rf = acc_refused;
		stall <= 1'h0;
		chk("access ends", cyc < 300, 1);
		chk("idle again", acc_ready, 1'h1);
	endtask : acc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axr(12'h000, d, r);
		chk("ctrl reset", d, DEF);
		axw(12'h000, 32'hffffffff, 4'hf, r);
		axr(12'h000, d, r);
		chk("ctrl masked", d, 32'h000fffff);
		axw(12'h000, 32'h00000000, 4'h3, r);
		chk("narrow resp", r, `BCSC_RESP_SLVERR);
		axr(12'h000, d, r);
		chk("narrow kept", d, 32'h000fffff);
		axr(12'h100, d, r);
		chk("unmapped resp", r, `BCSC_RESP_SLVERR);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_refuse();
		logic [31:0] v [5] = '{DEF & ~32'h1, DEF & ~32'h40, DEF | 32'h20, DEF | 32'hc, DEF & ~32'h30};
		for (int i = 0; i < 5; i++)
		begin
			set_ctrl(v[i]);
			acc(1'h0, 1'h0, 1'h0, 8'h1, 24'h10, 0);
			chk("refused", rf, i < 4);
		end
		chk("narrow bus", wd, 1'h0);
		set_ctrl(DEF & ~32'h1000);
		acc(1'h1, 1'h0, 1'h0, 8'h1, 24'h10, 0);
		chk("write off", rf, 1'h1);
		$display("t_refuse done");
	endtask : t_refuse

	task automatic t_modes();
		set_ctrl(DEF);
		acc(1'h1, 1'h0, 1'h0, 8'h2, 24'h20, 0);
		chk("async write", {sy, tm, wr, ck, 6'(lat)}, {1'h0, 1'h0, 1'h1, 1'h0, 6'h2});
		set_ctrl(DEF | 32'h00080000);
		acc(1'h1, 1'h0, 1'h0, 8'h2, 24'h20, 0);
		chk("sync write", {sy, ck, 6'(lat)}, {1'h1, 1'h1, 6'h1});
		set_ctrl(DEF | 32'h00004000);
		acc(1'h1, 1'h0, 1'h0, 8'h1, 24'h20, 0);
		chk("write timing", tm, 1'h1);
		acc(1'h0, 1'h0, 1'h0, 8'h1, 24'h20, 0);
		chk("read timing", {wr, tm}, 2'h0);
		set_ctrl(DEF);
		acc(1'h0, 1'h1, 1'h0, 8'h2, 24'h20, 0);
		chk("burst off", sy, 1'h0);
		$display("t_modes done");
	endtask : t_modes

	task automatic t_split();
		for (int k = 0; k < 5; k++)
		begin
			set_ctrl(SB | (k << 16));
			acc(1'h0, 1'h1, 1'h0, 8'h2, 24'((32'h40 << k) - 2), 0);
			chk("page split", {sy, 6'(lat)}, {1'h1, (k == 0) ? 6'h1 : 6'h2});
			chk("page addr", ad, (k == 0) ? 24'h00003e : 24'(32'h40 << k));
		end
		set_ctrl(SB);
		acc(1'h0, 1'h1, 1'h1, 8'h4, 24'h4, 0);
		chk("wrap split", lat, 2);
		chk("wrap restart", {ad, 8'(nb)}, {24'h000000, 8'h04});
		set_ctrl(SB | 32'h400);
		acc(1'h0, 1'h1, 1'h1, 8'h4, 24'h4, 0);
		chk("wrap direct", lat, 1);
		$display("t_split done");
	endtask : t_split

	task automatic t_wait();
		int base;
		set_ctrl(SB);
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 0);
		base = cyc;
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 10);
		chk("sync wait", cyc > base, 1);
		set_ctrl(SB & ~32'h2000);
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 10);
		chk("sync wait off", cyc == base, 1);
		set_ctrl(SB | 32'h800);
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 10);
		chk("wait in place", cyc > base, 1);
		act_high <= 1'h1;
		set_ctrl(SB | 32'h200);
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 0);
		chk("high idle", cyc == base, 1);
		acc(1'h0, 1'h1, 1'h0, 8'h8, 24'h100, 10);
		chk("high wait", cyc > base, 1);
		act_high <= 1'h0;
		set_ctrl(DEF);
		acc(1'h0, 1'h0, 1'h0, 8'h8, 24'h100, 0);
		base = cyc;
		acc(1'h0, 1'h0, 1'h0, 8'h8, 24'h100, 10);
		chk("async wait off", cyc == base, 1);
		set_ctrl(DEF | 32'h8000);
		acc(1'h0, 1'h0, 1'h0, 8'h8, 24'h100, 10);
		chk("async wait", cyc > base, 1);
		$display("t_wait done");
	endtask : t_wait

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		t_regs();
		t_refuse();
		t_modes();
		t_split();
		t_wait();
		results();
	end

	// The ceiling is far above the few hundred cycles the scenarios need.
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_mismatch++;
			results();
		end
	end
endmodule : ext_mem_bank1_chip_select_control_tb
